// [design/cflt_pkg.sv]
package cflt_pkg;
    localparam int unsigned CFLT_COEF_W = 24;
    localparam int unsigned CFLT_MEM_DEPTH = 144;
    localparam logic [7:0] CFLT_OFS_LOCATION = 8'h1a;
    localparam logic [7:0] CFLT_OFS_VALUE_LO = 8'h1b;
    localparam logic [7:0] CFLT_OFS_VALUE_MID = 8'h1c;
    localparam logic [7:0] CFLT_OFS_VALUE_HI = 8'h1d;
    localparam logic [7:0] CFLT_OFS_CONTROL = 8'h1e;
    localparam int unsigned CFLT_LOC_STAGE_BIT = 7;
    localparam int unsigned CFLT_CTRL_SYM_BIT = 2;
    localparam int unsigned CFLT_CTRL_WE_BIT = 1;
    localparam int unsigned CFLT_CTRL_EN_BIT = 0;
    localparam logic [7:0] CFLT_LOCATION_RST = 8'h00;
    localparam logic [23:0] CFLT_VALUE_RST = 24'h000000;
    localparam logic [2:0] CFLT_CONTROL_RST = 3'h0;
    localparam logic [7:0] CFLT_STAGE1_DEPTH = 8'h80;
    localparam logic [6:0] CFLT_STAGE2_DEPTH = 7'h10;
    localparam logic [6:0] CFLT_STAGE2_USED = 7'h0e;
    localparam logic [6:0] CFLT_SINE_TAPS = 7'h1b;
    localparam logic [6:0] CFLT_COSINE_TAPS = 7'h1c;

    // Flat memory index: stage 1 first, stage 2 behind it
    function automatic logic [7:0] cflt_flat_idx(input logic stage,
                                                input logic [6:0] idx);
        cflt_flat_idx = stage ? (CFLT_STAGE1_DEPTH + {4'h0, idx[3:0]})
                              : {1'b0, idx};
    endfunction

    // Stage 2 tap to location, bit 4 set when the tap exists
    function automatic logic [4:0] cflt_mirror(input logic cosine,
                                              input logic [6:0] tap);
        logic [6:0] taps;
        logic [6:0] loc;
        taps = cosine ? CFLT_COSINE_TAPS : CFLT_SINE_TAPS;
        loc = (taps - 7'h01) - tap;
        if (tap < CFLT_STAGE2_USED) begin
            cflt_mirror = {1'b1, tap[3:0]};
        end else if (tap < taps) begin
            cflt_mirror = {1'b1, loc[3:0]};
        end else begin
            cflt_mirror = 5'h00;
        end
    endfunction
endpackage

// [design/cflt_coeff_mem.sv]
`timescale 1ns/1ps
module cflt_coeff_mem import cflt_pkg::*; (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic wr_en,
    input wire logic [7:0] wr_idx,
    input wire logic [23:0] wr_data,
    input wire logic [7:0] rd_idx,
    output logic [23:0] rd_data
);
    logic [23:0] word_ff [CFLT_MEM_DEPTH];

    // Reset to zero only for defined simulation, not a usable filter
    genvar gi;
    generate
        for (gi = 0; gi < CFLT_MEM_DEPTH; gi++) begin : g_word
            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    word_ff[gi] <= CFLT_VALUE_RST;
                end else if (wr_en && wr_idx == 8'(gi)) begin
                    word_ff[gi] <= wr_data;
                end
            end
        end
    endgenerate

    always_comb begin
        if (rd_idx < 8'(CFLT_MEM_DEPTH)) begin
            rd_data = word_ff[rd_idx];
        end else begin
            rd_data = 24'h000000;
        end
    end
endmodule

// [design/cflt_loader.sv]
`timescale 1ns/1ps
module cflt_loader import cflt_pkg::*; (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic interp_bypass_req,
    input wire logic tap_req,
    input wire logic tap_stage,
    input wire logic [6:0] tap_index,
    output logic [23:0] tap_coeff,
    output logic tap_valid,
    output logic custom_filter_active,
    output logic interp_filter_active,
    output logic stage2_cosine_symmetry,
    output logic [4:0] stage2_tap_count
);
    logic [7:0] location_ff;
    logic [23:0] value_ff;
    logic [2:0] control_ff;
    logic [7:0] rdata_ff;
    logic [23:0] tap_coeff_ff;
    logic tap_valid_ff;
    logic custom_ff;
    logic interp_ff;
    logic cosine_ff;
    logic [4:0] taps_ff;
    logic loc_stage;
    logic [6:0] loc_index;
    logic in_range;
    logic commit;
    logic [23:0] commit_word;
    logic [4:0] mirror;
    logic tap_ok;
    logic [7:0] rd_idx;
    logic [23:0] mem_word;

    assign loc_stage = location_ff[CFLT_LOC_STAGE_BIT];
    assign loc_index = location_ff[6:0];
    // Stage 2 index 16 and above dropped
    assign in_range = !loc_stage || (loc_index < CFLT_STAGE2_DEPTH);
    assign commit = reg_wr && reg_addr == CFLT_OFS_VALUE_HI && in_range
                    && control_ff[CFLT_CTRL_WE_BIT];
    // Top byte joins the held lower bytes
    assign commit_word = {reg_wdata, value_ff[15:0]};

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            location_ff <= CFLT_LOCATION_RST;
        end else if (reg_wr && reg_addr == CFLT_OFS_LOCATION) begin
            location_ff <= reg_wdata;
        end
    end

    // Three byte lanes of the word
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            value_ff <= CFLT_VALUE_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                CFLT_OFS_VALUE_LO: begin
                    value_ff[7:0] <= reg_wdata;
                end
                CFLT_OFS_VALUE_MID: begin
                    value_ff[15:8] <= reg_wdata;
                end
                CFLT_OFS_VALUE_HI: begin
                    value_ff[23:16] <= reg_wdata;
                end
                default: begin
                    value_ff <= value_ff;
                end
            endcase
        end
    end

    // Upper bits not stored, read as zero
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            control_ff <= CFLT_CONTROL_RST;
        end else if (reg_wr && reg_addr == CFLT_OFS_CONTROL) begin
            control_ff <= reg_wdata[2:0];
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                CFLT_OFS_LOCATION: begin
                    rdata_ff <= location_ff;
                end
                CFLT_OFS_VALUE_LO: begin
                    rdata_ff <= value_ff[7:0];
                end
                CFLT_OFS_VALUE_MID: begin
                    rdata_ff <= value_ff[15:8];
                end
                CFLT_OFS_VALUE_HI: begin
                    rdata_ff <= value_ff[23:16];
                end
                CFLT_OFS_CONTROL: begin
                    rdata_ff <= {5'h00, control_ff};
                end
                default: begin
                    rdata_ff <= 8'h00;
                end
            endcase
        end
    end

    // Only stage 2 locations 0 to 13 reach the filter
    assign mirror = cflt_mirror(control_ff[CFLT_CTRL_SYM_BIT], tap_index);
    assign tap_ok = !tap_stage || mirror[4];
    assign rd_idx = tap_stage ? cflt_flat_idx(1'b1, {3'h0, mirror[3:0]})
                              : cflt_flat_idx(1'b0, tap_index);

    cflt_coeff_mem u_mem (
        .mclk(mclk),
        .arst_n(arst_n),
        .wr_en(commit),
        .wr_idx(cflt_flat_idx(loc_stage, loc_index)),
        .wr_data(commit_word),
        .rd_idx(rd_idx),
        .rd_data(mem_word)
    );

    // Missing taps read as zero so the datapath needs no length logic
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tap_coeff_ff <= 24'h000000;
            tap_valid_ff <= 1'b0;
        end else begin
            tap_valid_ff <= tap_req;
            if (tap_req) begin
                tap_coeff_ff <= tap_ok ? mem_word : 24'h000000;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            custom_ff <= 1'b0;
            interp_ff <= 1'b1;
            cosine_ff <= 1'b0;
            taps_ff <= CFLT_SINE_TAPS[4:0];
        end else begin
            custom_ff <= control_ff[CFLT_CTRL_EN_BIT]
                         && !control_ff[CFLT_CTRL_WE_BIT];
            interp_ff <= !interp_bypass_req;
            cosine_ff <= control_ff[CFLT_CTRL_SYM_BIT];
            taps_ff <= control_ff[CFLT_CTRL_SYM_BIT] ? CFLT_COSINE_TAPS[4:0]
                                                     : CFLT_SINE_TAPS[4:0];
        end
    end

    assign reg_rdata = rdata_ff;
    assign tap_coeff = tap_coeff_ff;
    assign tap_valid = tap_valid_ff;
    assign custom_filter_active = custom_ff;
    assign interp_filter_active = interp_ff;
    assign stage2_cosine_symmetry = cosine_ff;
    assign stage2_tap_count = taps_ff;
endmodule

// [dv/cflt_checker.sv]
`timescale 1ns/1ps
module cflt_checker import cflt_pkg::*; (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic interp_bypass_req,
    input wire logic tap_req,
    input wire logic tap_stage,
    input wire logic [6:0] tap_index,
    input wire logic [23:0] tap_coeff,
    input wire logic tap_valid,
    input wire logic custom_filter_active,
    input wire logic interp_filter_active,
    input wire logic stage2_cosine_symmetry,
    input wire logic [4:0] stage2_tap_count
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence ctl_wr;
        reg_wr && reg_addr == CFLT_OFS_CONTROL;
    endsequence
    // Status lags the control write by two edges
    chk_we_bypass: assert property (ctl_wr ##0 reg_wdata[1] |-> ##2
        !custom_filter_active) else $error("custom active while loading");
    chk_en_select: assert property (ctl_wr ##0 reg_wdata[1:0] == 2'h1
        |-> ##2 custom_filter_active) else $error("custom not selected");
    chk_sym_follow: assert property (ctl_wr |-> ##2
        stage2_cosine_symmetry == $past(reg_wdata[2], 2))
        else $error("symmetry mismatch");
    chk_tap_count: assert property (stage2_tap_count ==
        (stage2_cosine_symmetry ? 5'h1c : 5'h1b)) else $error("tap count");
    chk_tap_answer: assert property (tap_req |=> tap_valid)
        else $error("tap not answered");
    chk_tap_idle: assert property (!tap_req |=> !tap_valid &&
        $stable(tap_coeff)) else $error("tap output moved");
    chk_tap_beyond: assert property (tap_req && tap_stage &&
        tap_index > 7'h1b |=> tap_coeff == 24'h0) else $error("tap beyond");
    chk_interp_path: assert property (interp_bypass_req |=>
        !interp_filter_active) else $error("interpolator not bypassed");
    chk_ctrl_rsvd: assert property (reg_rd && reg_addr == 8'h1e |=>
        reg_rdata[7:3] == 5'h00) else $error("reserved bits read");
endmodule

// [dv/cflt_host.sv]
`timescale 1ns/1ps
module cflt_host (
    input wire logic mclk,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // Released lines show inverted values, never the last one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1 reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge mclk);
        #1 reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        #1 reg_addr = a;
        reg_rd = 1'b1;
        @(posedge mclk);
        #1 reg_rd = 1'b0;
        reg_addr = ~a;
        @(posedge mclk);
        #1 d = reg_rdata;
    endtask
    task automatic ctl(input logic [2:0] c);
        wr(8'h1e, {5'h00, c});
        @(posedge mclk);
        #1;
    endtask
    task automatic load(input logic s, input logic [6:0] i,
                        input logic [23:0] v);
        wr(8'h1a, {s, i});
        wr(8'h1b, v[7:0]);
        wr(8'h1c, v[15:8]);
        wr(8'h1d, v[23:16]);
    endtask
endmodule

// [dv/custom_filter_coeff_loader_tb.sv]
`timescale 1ns/1ps
module custom_filter_coeff_loader_tb;
    logic mclk, arst_n, reg_wr, reg_rd, interp_bypass_req, tap_req;
    logic tap_stage, tap_valid, custom_filter_active, interp_filter_active;
    logic stage2_cosine_symmetry;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [6:0] tap_index;
    logic [23:0] tap_coeff;
    logic [4:0] stage2_tap_count;
    int num_errors, checks, cyc;
    cflt_loader DUT (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .interp_bypass_req(interp_bypass_req),
        .tap_req(tap_req), .tap_stage(tap_stage), .tap_index(tap_index),
        .tap_coeff(tap_coeff), .tap_valid(tap_valid),
        .custom_filter_active(custom_filter_active),
        .interp_filter_active(interp_filter_active),
        .stage2_cosine_symmetry(stage2_cosine_symmetry),
        .stage2_tap_count(stage2_tap_count));
    cflt_host HOST (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        HOST.rd(a, d);
        chk(d, e);
    endtask
    task automatic tap(input logic s, input logic [6:0] i,
                       input logic [23:0] e);
        @(posedge mclk);
        #1 tap_req = 1'b1;
        tap_stage = s;
        tap_index = i;
        @(posedge mclk);
        #1 tap_req = 1'b0;
        tap_index = ~i;
        chk(tap_valid, 1'b1);
        chk(tap_coeff, e);
    endtask
    task automatic t_reset;
        for (int a = 8'h1a; a <= 8'h1e; a++) rchk(a, 8'h00);
        rchk(8'h20, 8'h00);
        chk(interp_filter_active, 1'b1);
        chk({custom_filter_active, stage2_tap_count}, 6'h1b);
        $display("test reset done");
    endtask
    task automatic t_load;
        HOST.ctl(3'h2);
        chk(custom_filter_active, 1'b0);
        HOST.load(1'b0, 7'h7f, 24'habcdef);
        for (int i = 0; i < 16; i++)
            HOST.load(1'b1, i, i < 14 ? 24'h100 + i : 24'heeeeee);
        HOST.load(1'b1, 7'h10, 24'h555555);
        rchk(8'h1d, 8'h55);
        rchk(8'h1a, 8'h90);
        HOST.ctl(3'h0);
        HOST.load(1'b0, 7'h7f, 24'h123456);
        $display("test load done");
    endtask
    task automatic t_select;
        interp_bypass_req = 1'b1;
        HOST.ctl(3'h1);
        chk(custom_filter_active, 1'b1);
        HOST.ctl(3'h3);
        chk({custom_filter_active, interp_filter_active}, 2'h0);
        HOST.ctl(3'h1);
        chk(custom_filter_active, 1'b1);
        interp_bypass_req = 1'b0;
        rchk(8'h1e, 8'h01);
        tap(1'b0, 7'h7f, 24'habcdef);
        $display("test select done");
    endtask
    task automatic t_mirror;
        int n;
        logic [23:0] e;
        for (int c = 0; c < 2; c++) begin
            n = 27 + c;
            HOST.ctl({c[0], 2'h1});
            chk(stage2_tap_count, n);
            chk(stage2_cosine_symmetry, c[0]);
            for (int t = 0; t <= n; t++) begin
                e = t == n ? 24'h0 : 24'h100 + 24'(t < 14 ? t : n - 1 - t);
                tap(1'b1, t, e);
            end
        end
        $display("test mirror done");
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            complete_run();
        end
    end
    initial begin
        arst_n = 1'b0;
        interp_bypass_req = 1'b0;
        tap_req = 1'b0;
        tap_stage = 1'b0;
        tap_index = 7'h00;
        repeat (5) @(posedge mclk);
        #1 arst_n = 1'b1;
        t_reset();
        t_load();
        t_select();
        t_mirror();
        complete_run();
    end
endmodule
bind cflt_loader cflt_checker CHK (.mclk(mclk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .interp_bypass_req(interp_bypass_req), .tap_req(tap_req),
    .tap_stage(tap_stage), .tap_index(tap_index), .tap_coeff(tap_coeff),
    .tap_valid(tap_valid), .custom_filter_active(custom_filter_active),
    .interp_filter_active(interp_filter_active),
    .stage2_cosine_symmetry(stage2_cosine_symmetry),
    .stage2_tap_count(stage2_tap_count));
